// >>> verilog/mfp_pkg.sv
package mfp_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_P2_DAT = 8'h11;
  localparam logic [7:0] IDX_P2_DIR = 8'h17;
  localparam logic [7:0] IDX_P2_FC  = 8'h16;
  localparam logic [7:0] IDX_P3_DAT = 8'h1B;
  localparam logic [7:0] IDX_P3_DIR = 8'h19;
  localparam logic [7:0] IDX_P3_FC  = 8'h18;
  localparam logic [7:0] IDX_P4_DAT = 8'h1D;
  localparam logic [7:0] IDX_P4_DIR = 8'h23;
  localparam logic [7:0] IDX_P4_FC  = 8'h22;
  localparam logic [7:0] IDX_P5_DAT = 8'h2B;
  localparam logic [7:0] IDX_P5_DIR = 8'h2F;
  localparam logic [7:0] IDX_P5_FC  = 8'h2E;

  // ****************************************
  // register kinds and port slots
  // ****************************************
  localparam logic [1:0] K_DAT = 2'h0;
  localparam logic [1:0] K_DIR = 2'h1;
  localparam logic [1:0] K_FC  = 2'h2;
  localparam logic [1:0] S_P2  = 2'h0;
  localparam logic [1:0] S_P3  = 2'h1;
  localparam logic [1:0] S_P4  = 2'h2;
  localparam logic [1:0] S_P5  = 2'h3;

  // ****************************************
  // reset values and bit masks
  // ****************************************
  localparam logic [7:0] RST_P2_DAT  = 8'h00;
  localparam logic [7:0] RST_P3_DAT  = 8'h03;
  localparam logic [7:0] RST_P4_DAT  = 8'h10;
  localparam logic [7:0] RST_P5_DAT  = 8'hFF;
  localparam logic [7:0] RST_DIR     = 8'h00;
  localparam logic [7:0] RST_FC      = 8'h00;
  localparam logic [7:0] P3_DIR_MASK = 8'hFC;
  localparam logic [7:0] P3_OUT_ONLY = 8'h03;
  localparam logic [7:0] P3_PU_PINS  = 8'h7C;
  localparam logic [7:0] P3_BUS_GRANT_ACKNOWLEDGE_PU = 8'h44;
  localparam logic [7:0] P4_MASK     = 8'h1F;
  localparam logic [7:0] P4_PU_PINS  = 8'h0F;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [7:0] fc;
    logic [7:0] dir;
    logic [7:0] dat;
  } mfp_port_type;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe_n;
    logic [7:0] pu;
  } mfp_pad_type;

  typedef enum logic {
    ST_LOAD = 1'b0,
    ST_RUN  = 1'b1
  } mfp_state_type;

endpackage : mfp_pkg

// >>> verilog/mfp_port.sv
`timescale 1ns/10ps

// Behaviour
// - port 2 pair fc,dir: 00 in, 01 out, 10 addr low, 11 addr high
// - bus mode strap sampled at reset; low separate, high multiplexed
// - port 3 pins 0 and 1 always drive, gpio or strobe
// - port 3 pins pick gpio or control per pin by fc; dir sets gpio direction
// - reset: p3 latch bits 0,1 set; bits 2-6 follow pull-up strap
// - reset: p3 latch bit 7 set in separate mode, cleared in multiplexed
// - reset: p3 direction bits 2-6 cleared; bits 0,1 unused
// - reset: p3 direction bit 7 equals bus mode, output when multiplexed
// - after reset p3 pins 2-6 inputs, pull-ups follow strap
// - p3 pin 0 with fc set carries active-low read strobe
// - p3 pin 1 with fc set carries active-low write strobe
// - bus grant ack enables pull-ups on p3 pins 2,6 with fc set
// - p4 pins 0-3: gpio when fc 0, chip selects when fc 1
// - p4 pin 4: gpio when fc 0, system clock output when fc 1
// - reset: p4 latch bits 0-3 follow pull-up strap, pins inputs
// - reset: p4 latch bit 4 set regardless of strap
// - reset: p4 dir and fc cleared; pin 4 pull-up always off
// - reset: p5 latch all ones, dir and fc cleared, inputs
// - p5 address only in separate mode; software configures first
// - port 5 pair fc,dir: 00 in, 01 out, 10 in, 11 addr low
module mfp_port
  import mfp_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  // straps
  input  wire logic              bus_mode_strap_i,
  input  wire logic              reset_pullup_strap_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // dedicated functions
  input  wire logic [23:0]       addr_i,
  input  wire logic              read_strobe_n_i,
  input  wire logic              write_strobe_n_i,
  input  wire logic [7:2]        ctrl_out_i,
  input  wire logic [7:2]        ctrl_oe_i,
  input  wire logic              bus_grant_acknowledge_i,
  input  wire logic [3:0]        chip_select_n_i,
  input  wire logic              system_clock_i,
  output logic                   bus_mode_o,
  // pads
  input  wire logic [7:0]        p2_pin_i,
  input  wire logic [7:0]        p3_pin_i,
  input  wire logic [7:0]        p4_pin_i,
  input  wire logic [7:0]        p5_pin_i,
  output mfp_pad_type            p2_pad_o,
  output mfp_pad_type            p3_pad_o,
  output mfp_pad_type            p4_pad_o,
  output mfp_pad_type            p5_pad_o
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [4:0] mfp_dec(input logic [7:0] a);
    case (a)
      IDX_P2_DAT: mfp_dec = {1'b1, S_P2, K_DAT};
      IDX_P2_DIR: mfp_dec = {1'b1, S_P2, K_DIR};
      IDX_P2_FC:  mfp_dec = {1'b1, S_P2, K_FC};
      IDX_P3_DAT: mfp_dec = {1'b1, S_P3, K_DAT};
      IDX_P3_DIR: mfp_dec = {1'b1, S_P3, K_DIR};
      IDX_P3_FC:  mfp_dec = {1'b1, S_P3, K_FC};
      IDX_P4_DAT: mfp_dec = {1'b1, S_P4, K_DAT};
      IDX_P4_DIR: mfp_dec = {1'b1, S_P4, K_DIR};
      IDX_P4_FC:  mfp_dec = {1'b1, S_P4, K_FC};
      IDX_P5_DAT: mfp_dec = {1'b1, S_P5, K_DAT};
      IDX_P5_DIR: mfp_dec = {1'b1, S_P5, K_DIR};
      IDX_P5_FC:  mfp_dec = {1'b1, S_P5, K_FC};
      default:    mfp_dec = 5'h00;
    endcase
  endfunction : mfp_dec

  function automatic logic [7:0] mfp_wmask(input logic [1:0] s, input logic [1:0] k);
    if (s == S_P4)
    begin
      mfp_wmask = P4_MASK;
    end
    else if (s == S_P3 && k == K_DIR)
    begin
      mfp_wmask = P3_DIR_MASK;
    end
    else
    begin
      mfp_wmask = 8'hFF;
    end
  endfunction : mfp_wmask

  function automatic logic [7:0] mfp_mix(input logic [7:0] drv, input logic [7:0] lat,
                                         input logic [7:0] pin);
    mfp_mix = (drv & lat) | (~drv & pin);
  endfunction : mfp_mix

  // ****************************************
  // state
  // ****************************************
  mfp_port_type  regs_reg [4];
  mfp_port_type  regs_next [4];
  mfp_state_type st_reg;
  mfp_state_type st_next;
  logic          bm_reg;
  logic          bm_next;
  logic          rdy_reg;
  logic          rdy_next;
  logic          err_reg;
  logic          err_next;
  logic [31:0]   prdata_reg;
  logic [31:0]   prdata_next;
  logic [4:0]    dec;
  logic [7:0]    gp [4];
  logic [7:0]    rd [4];
  logic [7:0]    pin [4];
  logic [7:0]    mw;
  logic          sep;
  logic          setup;
  logic          done;

  assign dec      = mfp_dec(paddr_i[9:2]);
  assign sep      = ~bm_reg;
  assign setup    = psel_i & ~penable_i & ~rdy_reg & (st_reg == ST_RUN);
  assign done     = psel_i & penable_i & rdy_reg & ce_i;
  assign pready_o = rdy_reg & ce_i;
  assign pslverr_o = err_reg;
  assign prdata_o  = prdata_reg;
  assign bus_mode_o = bm_reg;
  assign pin[0] = p2_pin_i;
  assign pin[1] = p3_pin_i;
  assign pin[2] = p4_pin_i;
  assign pin[3] = p5_pin_i;
  assign mw     = mfp_wmask(dec[3:2], dec[1:0]);

  // ****************************************
  // gpio drive masks and read values
  // ****************************************
  always_comb
  begin
    gp[0] = ~regs_reg[0].fc & regs_reg[0].dir;
    gp[1] = ~regs_reg[1].fc & (regs_reg[1].dir | P3_OUT_ONLY);
    gp[2] = ~regs_reg[2].fc & regs_reg[2].dir & P4_MASK;
    gp[3] = regs_reg[3].dir & ~(regs_reg[3].fc & {8{sep}});
    for (int i = 0; i < 4; i++)
    begin
      rd[i] = mfp_mix(gp[i], regs_reg[i].dat, pin[i]);
    end
    rd[2] = rd[2] & P4_MASK;
  end

  // ****************************************
  // register next values
  // ****************************************
  always_comb
  begin
    regs_next   = regs_reg;
    st_next     = st_reg;
    bm_next     = bm_reg;
    rdy_next    = rdy_reg;
    err_next    = err_reg;
    prdata_next = prdata_reg;
    case (st_reg)
      ST_LOAD:
      begin
        bm_next = bus_mode_strap_i;
        regs_next[1].dat = {~bus_mode_strap_i, {5{reset_pullup_strap_i}},
                            P3_OUT_ONLY[1:0]};
        regs_next[1].dir = {bus_mode_strap_i, RST_DIR[6:0]};
        regs_next[2].dat = {RST_P4_DAT[7:4], {4{reset_pullup_strap_i}}};
        st_next = ST_RUN;
      end
      ST_RUN:
      begin
        if (setup)
        begin
          rdy_next    = 1'b1;
          err_next    = ~dec[4];
          prdata_next = 32'h0000_0000;
          if (dec[4] && !pwrite_i && dec[1:0] == K_DAT)
          begin
            prdata_next = {24'h00_0000, rd[dec[3:2]]};
          end
        end
        if (done)
        begin
          rdy_next = 1'b0;
          if (pwrite_i && dec[4] && pstrb_i[0])
          begin
            case (dec[1:0])
              K_DAT:   regs_next[dec[3:2]].dat = pwdata_i[7:0] & mw;
              K_DIR:   regs_next[dec[3:2]].dir = pwdata_i[7:0] & mw;
              K_FC:    regs_next[dec[3:2]].fc  = pwdata_i[7:0] & mw;
              default: regs_next[dec[3:2]].fc  = regs_reg[dec[3:2]].fc;
            endcase
          end
        end
      end
      default:
      begin
        st_next = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      regs_reg[0] <= '{fc: RST_FC, dir: RST_DIR, dat: RST_P2_DAT};
      regs_reg[1] <= '{fc: RST_FC, dir: RST_DIR, dat: RST_P3_DAT};
      regs_reg[2] <= '{fc: RST_FC, dir: RST_DIR, dat: RST_P4_DAT};
      regs_reg[3] <= '{fc: RST_FC, dir: RST_DIR, dat: RST_P5_DAT};
      st_reg      <= ST_LOAD;
      bm_reg      <= 1'b0;
      rdy_reg     <= 1'b0;
      err_reg     <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      regs_reg   <= regs_next;
      st_reg     <= st_next;
      bm_reg     <= bm_next;
      rdy_reg    <= rdy_next;
      err_reg    <= err_next;
      prdata_reg <= prdata_next;
    end
  end

  // ****************************************
  // pad multiplexers
  // ****************************************
  always_comb
  begin
    p2_pad_o.o = (regs_reg[0].fc & regs_reg[0].dir & addr_i[23:16])
               | (regs_reg[0].fc & ~regs_reg[0].dir & addr_i[7:0])
               | (~regs_reg[0].fc & regs_reg[0].dat);
    p2_pad_o.oe_n = ~(regs_reg[0].fc | regs_reg[0].dir);
    p2_pad_o.pu   = 8'h00;

    p3_pad_o.o = (regs_reg[1].fc & {ctrl_out_i, write_strobe_n_i, read_strobe_n_i})
               | (~regs_reg[1].fc & regs_reg[1].dat);
    p3_pad_o.oe_n = ~(P3_OUT_ONLY | gp[1]
                    | (regs_reg[1].fc & {ctrl_oe_i, 2'b11}));
    p3_pad_o.pu = P3_PU_PINS
                & ((~regs_reg[1].fc & ~regs_reg[1].dir & regs_reg[1].dat)
                 | (regs_reg[1].fc & {8{bus_grant_acknowledge_i}} & P3_BUS_GRANT_ACKNOWLEDGE_PU));

    p4_pad_o.o = P4_MASK
               & ((regs_reg[2].fc & {3'h0, system_clock_i, chip_select_n_i})
                | (~regs_reg[2].fc & regs_reg[2].dat));
    p4_pad_o.oe_n = ~(P4_MASK & (regs_reg[2].fc | regs_reg[2].dir));
    p4_pad_o.pu = P4_PU_PINS & ~regs_reg[2].fc & ~regs_reg[2].dir
                & regs_reg[2].dat;

    p5_pad_o.o = (regs_reg[3].fc & regs_reg[3].dir & {8{sep}} & addr_i[7:0])
               | (~(regs_reg[3].fc & {8{sep}}) & regs_reg[3].dat);
    p5_pad_o.oe_n = ~regs_reg[3].dir;
    p5_pad_o.pu   = 8'h00;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_p2_addr_lo;
    ((regs_reg[0].fc & ~regs_reg[0].dir & (p2_pad_o.o ^ addr_i[7:0])) == 8'h00)
    && ((regs_reg[0].fc & p2_pad_o.oe_n) == 8'h00);
  endproperty
  a_p2_addr_lo: assert property (p_p2_addr_lo) else $error("p2 address low");

  property p_p3_out_only;
    p3_pad_o.oe_n[1:0] == 2'b00;
  endproperty
  a_p3_out_only: assert property (p_p3_out_only) else $error("p3 pin 0/1 not driven");

  property p_p3_load;
    (st_reg == ST_LOAD && ce_i && reset_n_i) |=> regs_reg[1].dat ==
      {~$past(bus_mode_strap_i), {5{$past(reset_pullup_strap_i)}}, 2'b11};
  endproperty
  a_p3_load: assert property (p_p3_load) else $error("p3 latch reset");

  property p_p3_dir_load;
    (st_reg == ST_LOAD && ce_i && reset_n_i) |=>
      regs_reg[1].dir == {$past(bus_mode_strap_i), 7'h00} && bm_reg == $past(bus_mode_strap_i);
  endproperty
  a_p3_dir_load: assert property (p_p3_dir_load) else $error("p3 dir reset");

  property p_p4_load;
    (st_reg == ST_LOAD && ce_i && reset_n_i) |=>
      regs_reg[2].dat[4:0] == {1'b1, {4{$past(reset_pullup_strap_i)}}};
  endproperty
  a_p4_load: assert property (p_p4_load) else $error("p4 latch reset");

  property p_bus_grant_acknowledge_pu;
    (bus_grant_acknowledge_i && regs_reg[1].fc[6]) |-> p3_pad_o.pu[6] && !p3_pad_o.oe_n[6] == ctrl_oe_i[6];
  endproperty
  a_bus_grant_acknowledge_pu: assert property (p_bus_grant_acknowledge_pu) else $error("p3 pin 6 pull-up");

  property p_cs;
    regs_reg[2].fc[0] |-> p4_pad_o.o[0] == chip_select_n_i[0] && !p4_pad_o.oe_n[0];
  endproperty
  a_cs: assert property (p_cs) else $error("p4 chip select");

  property p_sclk;
    regs_reg[2].fc[4] |-> p4_pad_o.o[4] == system_clock_i && p4_pad_o.pu[4] == 1'b0;
  endproperty
  a_sclk: assert property (p_sclk) else $error("p4 clock out");

  property p_p5_in;
    ((regs_reg[3].fc & ~regs_reg[3].dir & ~p5_pad_o.oe_n) == 8'h00);
  endproperty
  a_p5_in: assert property (p_p5_in) else $error("p5 10 not input");

  property p_rd_strobe;
    regs_reg[1].fc[0] |-> p3_pad_o.o[0] == read_strobe_n_i;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("p3 read strobe");

  c_load:  cover property (st_reg == ST_LOAD ##1 st_reg == ST_RUN);
  c_write: cover property (done && pwrite_i && !err_reg);
  c_bus_grant_acknowledge: cover property (bus_grant_acknowledge_i && p3_pad_o.pu[2]);

endmodule : mfp_port

// >>> bench/mfp_board.sv
`timescale 1ns/10ps

// ****
// board side: pin levels seen by the port
// ****
module mfp_board
  import mfp_pkg::*;
(
  // pads from the port
  input  wire mfp_pad_type [3:0]      pads_i,
  // levels of undriven, unpulled pins
  input  wire logic        [31:0]     ext_i,
  // resolved pin levels
  output logic             [3:0][7:0] pins_o
);
  always_comb
  begin
    for (int s = 0; s < 4; s++)
    begin
      pins_o[s] = (~pads_i[s].oe_n & pads_i[s].o) | (pads_i[s].oe_n & pads_i[s].pu)
                | (pads_i[s].oe_n & ~pads_i[s].pu & ext_i[8*s+:8]);
    end
  end
endmodule : mfp_board

// >>> bench/mfp_port_tb.sv
`timescale 1ns/10ps

module mfp_port_tb;
  import mfp_pkg::*;
  logic              clk_i, reset_n_i, bm_s, pu_s, psel, penable, pwrite, pready, pslverr, bmode;
  logic              bus_grant_acknowledge, rd_n, wr_n, sclk;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, ext, rd;
  logic [23:0]       addr;
  logic [7:2]        c_out, c_oe;
  logic [3:0]        cs;
  logic              er;
  mfp_pad_type [3:0] pads;
  logic [3:0][7:0]   pins;
  logic [7:0]        m [4][3];
  logic [7:0]        v;
  logic [7:0]        idx_tab [4][3] = '{'{IDX_P2_DAT, IDX_P2_DIR, IDX_P2_FC}, '{IDX_P3_DAT, IDX_P3_DIR, IDX_P3_FC},
                                       '{IDX_P4_DAT, IDX_P4_DIR, IDX_P4_FC}, '{IDX_P5_DAT, IDX_P5_DIR, IDX_P5_FC}};
  int                mismatches, n_tests, c, s, k;

  mfp_port #(.ADDR_W(12)) mfp_port_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .bus_mode_strap_i(bm_s), .reset_pullup_strap_i(pu_s), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .addr_i(addr), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .ctrl_out_i(c_out), .ctrl_oe_i(c_oe), .bus_grant_acknowledge_i(bus_grant_acknowledge),
    .chip_select_n_i(cs), .system_clock_i(sclk), .bus_mode_o(bmode), .p2_pin_i(pins[0]),
    .p3_pin_i(pins[1]), .p4_pin_i(pins[2]), .p5_pin_i(pins[3]), .p2_pad_o(pads[0]),
    .p3_pad_o(pads[1]), .p4_pad_o(pads[2]), .p5_pad_o(pads[3]));

  mfp_board mfp_board_inst (.pads_i(pads), .ext_i(ext), .pins_o(pins));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ****
  // helpers
  // ****
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [11:0] ra(input int s, input int k);
    return {2'b00, idx_tab[s][k], 2'b00};
  endfunction : ra

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      mismatches++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic mfp_pad_type exp_pad(input int s);
    mfp_pad_type e;
    logic [7:0]  d, r, f;
    d = m[s][0];
    r = m[s][1];
    f = m[s][2];
    e.pu = 8'h00;
    e.oe_n = ~r;
    e.o = d;
    case (s)
      0:
      begin
        e.oe_n = ~(f | r);
        e.o = (f & r & addr[23:16]) | (f & ~r & addr[7:0]) | (~f & d);
      end
      1:
      begin
        e.oe_n = {(f[7:2] & ~c_oe) | (~f[7:2] & ~r[7:2]), 2'b00};
        e.o = (f & {c_out, wr_n, rd_n}) | (~f & d);
        e.pu = (~f & ~r & d & 8'h7C) | ({8{bus_grant_acknowledge}} & f & 8'h44);
      end
      2:
      begin
        e.oe_n = {3'b111, ~(f[4:0] | r[4:0])};
        e.o = {3'b000, (f[4:0] & {sclk, cs}) | (~f[4:0] & d[4:0])};
        e.pu = ~f & ~r & d & 8'h0F;
      end
      default: if (!bm_s) e.o = (f & addr[7:0]) | (~f & d);
    endcase
    return e;
  endfunction : exp_pad

  task check_all();
    mfp_pad_type e;
    logic [7:0]  lv, mk;
    @(negedge clk_i);
    chk("bus_mode", {7'h0, bm_s}, {7'h0, bmode});
    for (int i = 0; i < 4; i++)
    begin
      e = exp_pad(i);
      chk("pad_oe_n", e.oe_n, pads[i].oe_n);
      chk("pad_pu", e.pu, pads[i].pu);
      chk("pad_o", e.o & ~e.oe_n, pads[i].o & ~e.oe_n);
      lv = (~e.oe_n & e.o) | (e.oe_n & e.pu) | (e.oe_n & ~e.pu & ext[8*i+:8]);
      mk = (i == 2) ? 8'h1F : 8'hFF;
      apb(1'b0, ra(i, 0), 8'h00);
      chk("read_data", lv & mk, rd[7:0] & mk);
      chk("read_err", 8'h00, {7'h0, er});
    end
  endtask : check_all

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // ****
  // main sequence
  // ****
  initial
  begin
    {reset_n_i, psel, penable, pwrite, paddr, pwdata, bm_s, pu_s, addr, c_out, c_oe, bus_grant_acknowledge, sclk, ext} = '0;
    {rd_n, wr_n, cs} = 6'h3F;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(32'h6913));
    for (c = 0; c < 4; c++)
    begin
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      bm_s      <= c[1];
      pu_s      <= c[0];
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      m[0] = '{8'h00, 8'h00, 8'h00};
      m[1] = '{{~bm_s, {5{pu_s}}, 2'b11}, {bm_s, 7'h00}, 8'h00};
      m[2] = '{{3'b000, 1'b1, {4{pu_s}}}, 8'h00, 8'h00};
      m[3] = '{8'hFF, 8'h00, 8'h00};
      check_all();
      repeat (25)
      begin
        @(posedge clk_i);
        {addr, rd_n, wr_n, bus_grant_acknowledge, sclk} <= 28'($urandom);
        {c_out, c_oe, cs} <= 16'($urandom);
        ext <= $urandom;
        s = int'($urandom % 4);
        k = int'($urandom % 3);
        v = 8'($urandom);
        if (s == 1 && k == 1)
          v = v & 8'hFC;
        if (s == 2)
          v = v & 8'h1F;
        apb(1'b1, ra(s, k), v);
        chk("write_err", 8'h00, {7'h0, er});
        m[s][k] = v;
        apb(1'b0, ra(int'($urandom % 4), 1 + int'($urandom % 2)), 8'h00);
        chk("write_only_read", 8'h00, rd[7:0]);
        check_all();
      end
      apb(1'b1, 12'h000, 8'hFF);
      chk("unmapped_err", 8'h01, {7'h0, er});
      check_all();
    end
    tally_and_finish();
  end

  initial
  begin
    repeat (30000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end
endmodule : mfp_port_tb
